/* rtl/dtp_output_stage.sv */
// output stage: registers, wideband gain and test pattern selection
`timescale 1ns/100ps
`default_nettype none
module dtp_output_stage #(
    parameter int W = 16
) (
    input  wire logic         mclk_i,         // sample clock, 100 MHz
    input  wire logic         arst_n_i,       // async reset, low
    input  wire logic         reg_wr_i,       // register write strobe
    input  wire logic [7:0]   reg_addr_i,     // register address
    input  wire logic [7:0]   reg_wdata_i,    // register write data
    output logic      [7:0]   reg_rdata_o,    // read data, one cycle after address
    input  wire logic         smp_valid_i,    // input samples valid
    input  wire logic         wb_path_i,      // high-bandwidth filter path active
    input  wire logic [W-1:0] smp_inph_i,     // in-phase sample
    input  wire logic [W-1:0] smp_quad_i,     // quadrature sample
    output logic              out_valid_o,    // output samples valid
    output logic      [W-1:0] out_inph_o,     // in-phase output
    output logic      [W-1:0] out_quad_o,     // quadrature output
    output logic      [2:0]   latency_align_sel_o // latency alignment code
);
    // ========================================
    // registers
    logic       wideband_path_double_gain_q;
    logic [7:0] word1_lo_q;
    logic [7:0] word1_hi_q;
    logic [7:0] word2_lo_q;
    logic [7:0] word2_hi_q;
    logic [3:0] chan_sel_q;
    logic [3:0] second_downconv_inphase_choice_q;
    logic [3:0] second_downconv_quad_choice_q;
    logic       stream_en_q;

    // only live fields are stored; must-be-zero bits are dropped [RULE18]
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latency_align_sel_o <= dtp_pkg::RST_LAT;
        end else if (reg_wr_i && reg_addr_i == dtp_pkg::ADDR_LAT_ALIGN) begin
            latency_align_sel_o <= reg_wdata_i[dtp_pkg::LAT_MSB:dtp_pkg::LAT_LSB]; // [RULE1]
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wideband_path_double_gain_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == dtp_pkg::ADDR_WB_GAIN) begin
            wideband_path_double_gain_q <= reg_wdata_i[dtp_pkg::WB_GAIN_BIT]; // [RULE4]
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word1_lo_q <= dtp_pkg::RST_BYTE;
            word1_hi_q <= dtp_pkg::RST_BYTE;
            word2_lo_q <= dtp_pkg::RST_BYTE;
            word2_hi_q <= dtp_pkg::RST_BYTE;
        end else if (reg_wr_i) begin
            if (reg_addr_i == dtp_pkg::ADDR_WORD1_LO) begin
                word1_lo_q <= reg_wdata_i; // [RULE6]
            end
            if (reg_addr_i == dtp_pkg::ADDR_WORD1_HI) begin
                word1_hi_q <= reg_wdata_i; // [RULE6]
            end
            if (reg_addr_i == dtp_pkg::ADDR_WORD2_LO) begin
                word2_lo_q <= reg_wdata_i; // [RULE6]
            end
            if (reg_addr_i == dtp_pkg::ADDR_WORD2_HI) begin
                word2_hi_q <= reg_wdata_i; // [RULE6]
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chan_sel_q                       <= dtp_pkg::RST_SEL;
            second_downconv_inphase_choice_q <= dtp_pkg::RST_SEL;
            second_downconv_quad_choice_q    <= dtp_pkg::RST_SEL;
            stream_en_q                      <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == dtp_pkg::ADDR_CHAN_PAT) begin
                chan_sel_q <= reg_wdata_i[dtp_pkg::SEL_LO_LSB +: 4];
            end
            if (reg_addr_i == dtp_pkg::ADDR_DDC2_PAT) begin
                second_downconv_inphase_choice_q <=
                    reg_wdata_i[dtp_pkg::SEL_LO_LSB +: 4]; // [RULE15]
                second_downconv_quad_choice_q    <=
                    reg_wdata_i[dtp_pkg::SEL_HI_LSB +: 4]; // [RULE15]
            end
            if (reg_addr_i == dtp_pkg::ADDR_STREAM_EN) begin
                stream_en_q <= reg_wdata_i[dtp_pkg::STREAM_EN_BIT];
            end
        end
    end

    // ========================================
    // register read-back
    logic [7:0] rd_d;

    always_comb begin
        rd_d = 8'h00;
        unique case (reg_addr_i)
            dtp_pkg::ADDR_LAT_ALIGN: rd_d[dtp_pkg::LAT_MSB:dtp_pkg::LAT_LSB] = latency_align_sel_o;
            dtp_pkg::ADDR_WB_GAIN:   rd_d[dtp_pkg::WB_GAIN_BIT] = wideband_path_double_gain_q;
            dtp_pkg::ADDR_WORD1_LO:  rd_d = word1_lo_q;
            dtp_pkg::ADDR_WORD1_HI:  rd_d = word1_hi_q;
            dtp_pkg::ADDR_WORD2_LO:  rd_d = word2_lo_q;
            dtp_pkg::ADDR_WORD2_HI:  rd_d = word2_hi_q;
            dtp_pkg::ADDR_CHAN_PAT:  rd_d[dtp_pkg::SEL_LO_LSB +: 4] = chan_sel_q;
            dtp_pkg::ADDR_DDC2_PAT:  begin
                rd_d = {second_downconv_quad_choice_q, second_downconv_inphase_choice_q};
            end
            dtp_pkg::ADDR_STREAM_EN: rd_d[dtp_pkg::STREAM_EN_BIT] = stream_en_q;
            default:                 rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rd_d;
        end
    end

    // ========================================
    // wideband doubling gain
    logic         dbl_en;
    logic [W-1:0] gain_inph;
    logic [W-1:0] gain_quad;

    // doubling saturates rather than wraps, so a full-scale tone clips cleanly
    function automatic logic [W-1:0] dbl_sat(input logic [W-1:0] x);
        logic [W-1:0] r;
        r = {x[W-2:0], 1'b0};
        if (x[W-1] != x[W-2]) begin
            r = x[W-1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end
        return r;
    endfunction

    assign dbl_en    = wideband_path_double_gain_q && wb_path_i; // [RULE4] [RULE5]
    assign gain_inph = dbl_en ? dbl_sat(smp_inph_i) : smp_inph_i; // [RULE4]
    assign gain_quad = dbl_en ? dbl_sat(smp_quad_i) : smp_quad_i; // [RULE4]

    // ========================================
    // selector routing and generators, stream 0 in-phase, stream 1 quadrature
    logic [1:0][3:0]   stream_sel;
    logic [1:0][W-1:0] stream_smp;
    logic [1:0][W-1:0] stream_pat;
    logic [W-1:0]      word_one;
    logic [W-1:0]      word_two;

    assign stream_sel[0] = stream_en_q ? second_downconv_inphase_choice_q : chan_sel_q; // [RULE16]
    assign stream_sel[1] = stream_en_q ? second_downconv_quad_choice_q : chan_sel_q; // [RULE16]
    assign stream_smp[0] = gain_inph;
    assign stream_smp[1] = gain_quad;
    assign word_one      = W'({word1_hi_q, word1_lo_q});
    assign word_two      = W'({word2_hi_q, word2_lo_q});

    // both generators leave reset together, so their sequences stay aligned
    for (genvar g = 0; g < 2; g++) begin : g_stream
        dtp_pattern_gen #(
            .W          (W)
        ) u_gen (
            .mclk_i     (mclk_i),
            .arst_n_i   (arst_n_i),
            .sel_i      (stream_sel[g]),
            .smp_i      (stream_smp[g]),
            .word_one_i (word_one),
            .word_two_i (word_two),
            .pat_o      (stream_pat[g])
        );
    end

    assign out_inph_o = stream_pat[0];
    assign out_quad_o = stream_pat[1];

    // valid follows the one-cycle generator delay
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
        end else begin
            out_valid_o <= smp_valid_i;
        end
    end
endmodule
`default_nettype wire

/* rtl/dtp_pkg.sv */
// constants for the output-stage test pattern and gain block
//
// Notes on behaviour
// (RULE1) latency alignment field sits in bits 6 to 4, set per decimation ratio.
// (RULE2) software writes 10h for decimation 24/32, 20h for 16/18/20.
// (RULE3) software writes 40h for decimation 6/12, 50h for 4/8/9/10.
// (RULE4) wideband gain bit set doubles the wide filter output; clear passes unchanged.
// (RULE5) doubling applies only to the high-bandwidth path, decimation by 4 and 6.
// (RULE6) two 16-bit user words, low/high bytes at 33h/34h and 35h/36h.
// (RULE7) selector 0000 passes converter samples unchanged.
// (RULE8) selector 0001 outputs all zeros, 0010 outputs all ones.
// (RULE9) selector 0011 alternates alternating-bit word and its complement each sample.
// (RULE10) selector 0100 outputs a ramp rising one per clock from 0 to 16384.
// (RULE11) selector 0110 outputs the first user word continuously.
// (RULE12) selector 0111 alternates first and second user words each sample.
// (RULE13) selector 1000 outputs fixed deskew word AAAAh.
// (RULE14) selector 1001 outputs fixed sync word FFFFh.
// (RULE15) second converter has quadrature selector bits 7-4, in-phase bits 3-0.
// (RULE16) per-stream enable clear uses channel selector; set uses per-stream selectors.
// (RULE17) unlisted selector codes pass converter samples unchanged.
// (RULE18) reserved bits written zero; single pattern uses first user word registers.
package dtp_pkg;
    // ========================================
    // register offsets
    localparam logic [7:0] ADDR_LAT_ALIGN   = 8'h1E;
    localparam logic [7:0] ADDR_WB_GAIN     = 8'h1F;
    localparam logic [7:0] ADDR_WORD1_LO    = 8'h33;
    localparam logic [7:0] ADDR_WORD1_HI    = 8'h34;
    localparam logic [7:0] ADDR_WORD2_LO    = 8'h35;
    localparam logic [7:0] ADDR_WORD2_HI    = 8'h36;
    localparam logic [7:0] ADDR_CHAN_PAT    = 8'h37;
    localparam logic [7:0] ADDR_DDC2_PAT    = 8'h38;
    localparam logic [7:0] ADDR_STREAM_EN   = 8'h39;

    // ========================================
    // field positions and reset values
    localparam int         LAT_LSB          = 4;
    localparam int         LAT_MSB          = 6;
    localparam int         WB_GAIN_BIT      = 0;
    localparam int         STREAM_EN_BIT    = 0;
    localparam int         SEL_LO_LSB       = 0;
    localparam int         SEL_HI_LSB       = 4;
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic [3:0] RST_SEL          = 4'h0;
    localparam logic [2:0] RST_LAT          = 3'h0;

    // ========================================
    // pattern selector codes
    localparam logic [3:0] SEL_NORMAL       = 4'h0;
    localparam logic [3:0] SEL_ZEROS        = 4'h1;
    localparam logic [3:0] SEL_ONES         = 4'h2;
    localparam logic [3:0] SEL_TOGGLE       = 4'h3;
    localparam logic [3:0] SEL_RAMP         = 4'h4;
    localparam logic [3:0] SEL_SINGLE       = 4'h6;
    localparam logic [3:0] SEL_DOUBLE       = 4'h7;
    localparam logic [3:0] SEL_DESKEW       = 4'h8;
    localparam logic [3:0] SEL_SYNC         = 4'h9;

    // ========================================
    // fixed words and ramp limit
    localparam logic [15:0] TOGGLE_WORD     = 16'hAAAA;
    localparam logic [15:0] DESKEW_WORD     = 16'hAAAA;
    localparam logic [15:0] SYNC_WORD       = 16'hFFFF;
    localparam logic [15:0] RAMP_TOP        = 16'h4000;
endpackage

/* rtl/dtp_pattern_gen.sv */
// per-stream test pattern generator
`timescale 1ns/100ps
`default_nettype none
module dtp_pattern_gen #(
    parameter int W = 16
) (
    input  wire logic         mclk_i,       // sample clock
    input  wire logic         arst_n_i,     // async reset, low
    input  wire logic [3:0]   sel_i,        // pattern selector
    input  wire logic [W-1:0] smp_i,        // sample after gain
    input  wire logic [W-1:0] word_one_i,   // first user word
    input  wire logic [W-1:0] word_two_i,   // second user word
    output logic      [W-1:0] pat_o         // registered output word
);
    // ========================================
    // sequence state
    logic         phase_q;
    logic [W-1:0] ramp_q;

    // phase flips every clock so alternating patterns change per sample
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // ramp runs freely; wraps after the top code
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ramp_q <= '0;
        end else if (ramp_q == W'(dtp_pkg::RAMP_TOP)) begin
            ramp_q <= '0; // [RULE10]
        end else begin
            ramp_q <= ramp_q + W'(1); // [RULE10]
        end
    end

    // ========================================
    // output select
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pat_o <= '0;
        end else begin
            unique case (sel_i)
                dtp_pkg::SEL_ZEROS:  pat_o <= '0; // [RULE8]
                dtp_pkg::SEL_ONES:   pat_o <= '1; // [RULE8]
                dtp_pkg::SEL_TOGGLE: begin
                    pat_o <= phase_q ? ~W'(dtp_pkg::TOGGLE_WORD)
                                     : W'(dtp_pkg::TOGGLE_WORD); // [RULE9]
                end
                dtp_pkg::SEL_RAMP:   pat_o <= ramp_q; // [RULE10]
                dtp_pkg::SEL_SINGLE: pat_o <= word_one_i; // [RULE11] [RULE18]
                dtp_pkg::SEL_DOUBLE: pat_o <= phase_q ? word_two_i : word_one_i; // [RULE12]
                dtp_pkg::SEL_DESKEW: pat_o <= W'(dtp_pkg::DESKEW_WORD); // [RULE13]
                dtp_pkg::SEL_SYNC:   pat_o <= W'(dtp_pkg::SYNC_WORD); // [RULE14]
                default:             pat_o <= smp_i; // [RULE7] [RULE17]
            endcase
        end
    end
endmodule
`default_nettype wire

/* tb/dtp_output_stage_properties.sv */
// port assertions for the output stage
`timescale 1ns/100ps
`default_nettype none
module dtp_output_stage_properties #(
    parameter int W = 16
) (
    input wire logic         mclk_i,             // clock
    input wire logic         arst_n_i,           // reset, low
    input wire logic         reg_wr_i,           // write strobe
    input wire logic [7:0]   reg_addr_i,         // address
    input wire logic [7:0]   reg_wdata_i,        // write data
    input wire logic [7:0]   reg_rdata_o,        // read data
    input wire logic         smp_valid_i,        // sample valid
    input wire logic         wb_path_i,          // wide path
    input wire logic [W-1:0] smp_inph_i,         // I in
    input wire logic [W-1:0] smp_quad_i,         // Q in
    input wire logic         out_valid_o,        // valid out
    input wire logic [W-1:0] out_inph_o,         // I out
    input wire logic [W-1:0] out_quad_o,         // Q out
    input wire logic [2:0]   latency_align_sel_o // latency code
);
    // ====
    // shadow of mode registers, bit 4 is the per-stream enable
    logic [4:0] mode_q;
    logic       gain_q;
    logic [1:0] warm_q;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= 5'h00;
            gain_q <= 1'b0;
            warm_q <= 2'h0;
        end else begin
            warm_q <= {warm_q[0], 1'b1};
            if (reg_wr_i && reg_addr_i == 8'h37) mode_q[3:0] <= reg_wdata_i[3:0];
            if (reg_wr_i && reg_addr_i == 8'h39) mode_q[4] <= reg_wdata_i[0];
            if (reg_wr_i && reg_addr_i == 8'h1F) gain_q <= reg_wdata_i[0];
        end
    end
    // ====
    // properties; warm_q skips edges whose history reaches into reset
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    chk_lat_stored: assert property (reg_wr_i && reg_addr_i == 8'h1E |=>
        latency_align_sel_o == $past(reg_wdata_i[6:4])) else $error("latency code lost");
    chk_unmapped_zero: assert property (
        !(reg_addr_i inside {8'h1E, 8'h1F, [8'h33:8'h39]})
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    chk_pass_data: assert property (warm_q[1] && !$past(gain_q)
        && $past(mode_q) inside {5'h00, 5'h05, [5'h0A:5'h0F]}
        |-> out_inph_o == $past(smp_inph_i) && out_quad_o == $past(smp_quad_i))
        else $error("sample not passed");
    chk_gain_double: assert property (warm_q[1] && $past(mode_q) == 5'h00
        && $past(gain_q) && $past(wb_path_i)
        && $past(smp_inph_i[W-1]) == $past(smp_inph_i[W-2])
        |-> out_inph_o == {$past(smp_inph_i[W-2:0]), 1'b0}) else $error("gain not doubled");
    chk_all_zero: assert property (warm_q[1] && $past(mode_q) == 5'h01
        |-> out_inph_o == '0 && out_quad_o == '0) else $error("zeros wrong");
    chk_all_one: assert property (warm_q[1] && $past(mode_q) == 5'h02
        |-> out_inph_o == '1 && out_quad_o == '1) else $error("ones wrong");
    chk_toggle_word: assert property (warm_q[1] && $past(mode_q) == 5'h03
        && $past(mode_q, 2) == 5'h03 |-> out_inph_o == ~$past(out_inph_o)
        && out_inph_o inside {16'hAAAA, 16'h5555}) else $error("toggle wrong");
    chk_ramp_step: assert property (warm_q[1] && $past(mode_q) == 5'h04
        && $past(mode_q, 2) == 5'h04 |-> out_inph_o == $past(out_inph_o) + 16'h1
        || ($past(out_inph_o) == 16'h4000 && out_inph_o == 16'h0)) else $error("ramp wrong");
    chk_deskew_word: assert property (warm_q[1] && $past(mode_q) == 5'h08
        |-> out_inph_o == 16'hAAAA && out_quad_o == 16'hAAAA) else $error("deskew wrong");
    chk_sync_word: assert property (warm_q[1] && $past(mode_q) == 5'h09
        |-> out_inph_o == 16'hFFFF && out_quad_o == 16'hFFFF) else $error("sync wrong");
endmodule
bind dtp_output_stage dtp_output_stage_properties #(.W(W)) u_props (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .smp_valid_i(smp_valid_i),
    .wb_path_i(wb_path_i), .smp_inph_i(smp_inph_i), .smp_quad_i(smp_quad_i),
    .out_valid_o(out_valid_o), .out_inph_o(out_inph_o), .out_quad_o(out_quad_o),
    .latency_align_sel_o(latency_align_sel_o));
`default_nettype wire

/* tb/dtp_framer_model.sv */
// sink model of the serial link framer
`timescale 1ns/100ps
`default_nettype none
module dtp_framer_model (
    input  wire logic        mclk_i,   // sample clock
    input  wire logic        arst_n_i, // reset, low
    input  wire logic        valid_i,  // word pair valid
    output logic      [31:0] count_o   // pairs taken
);
    // framer never stalls, so every valid pair is taken
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= 32'h0;
        end else if (valid_i) begin
            count_o <= count_o + 32'h1;
        end
    end
endmodule
`default_nettype wire

/* tb/dtp_output_stage_tb.sv */
// self-checking bench for the output stage
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module dtp_output_stage_tb;
    logic        mclk_i, arst_n_i, reg_wr_i, smp_valid_i, wb_path_i, out_valid_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [15:0] smp_inph_i, smp_quad_i, out_inph_o, out_quad_o;
    logic [2:0]  latency_align_sel_o;
    logic [31:0] cnt;
    int          num_errors, cmp_count, cyc;
    dtp_output_stage #(.W(16)) DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .smp_valid_i(smp_valid_i), .wb_path_i(wb_path_i), .smp_inph_i(smp_inph_i),
        .smp_quad_i(smp_quad_i), .out_valid_o(out_valid_o), .out_inph_o(out_inph_o),
        .out_quad_o(out_quad_o), .latency_align_sel_o(latency_align_sel_o));
    dtp_framer_model u_framer (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .valid_i(out_valid_o),
        .count_o(cnt));
    always #5 mclk_i = ~mclk_i;
    // ====
    // bus helpers
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        tick();
        `CHK(reg_rdata_o, e)
    endtask
    task automatic results();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ====
    // scenarios
    task automatic t_regs();
        logic [7:0] ad [10] = '{8'h1E, 8'h1F, 8'h33, 8'h34, 8'h35,
                                8'h36, 8'h37, 8'h38, 8'h39, 8'h40};
        logic [7:0] rb [10] = '{8'h50, 8'h01, 8'h5A, 8'hC3, 8'h96,
                                8'h3C, 8'h0F, 8'hE7, 8'h01, 8'h00};
        logic [7:0] lat [4] = '{8'h10, 8'h20, 8'h40, 8'h50};
        foreach (ad[i]) rd(ad[i], 8'h00);
        foreach (ad[i]) begin
            wr(ad[i], (i == 9) ? 8'hFF : rb[i]);
            rd(ad[i], rb[i]);
        end
        foreach (lat[i]) begin
            wr(8'h1E, lat[i]);
            tick();
            `CHK(latency_align_sel_o, lat[i][6:4])
        end
    endtask
    task automatic t_patterns();
        logic [15:0] a;
        wr(8'h39, 8'h00);
        wr(8'h1F, 8'h00);
        wr(8'h33, 8'h34);
        wr(8'h34, 8'h12);
        wr(8'h35, 8'hCD);
        wr(8'h36, 8'hAB);
        for (int c = 0; c < 16; c++) begin
            wr(8'h37, 8'(c));
            tick();
            tick();
            a = out_inph_o;
            tick();
            case (c)
                1: `CHK({out_inph_o, out_quad_o}, 32'h0)
                2: `CHK({out_inph_o, out_quad_o}, 32'hFFFFFFFF)
                3: `CHK({out_inph_o, a == 16'hAAAA || a == 16'h5555}, {~a, 1'b1})
                4: `CHK(out_inph_o, (a == 16'h4000) ? 16'h0 : a + 16'h1)
                6: `CHK({out_inph_o, out_quad_o}, 32'h12341234)
                7: `CHK(out_inph_o, (a == 16'h1234) ? 16'hABCD : 16'h1234)
                8: `CHK({out_inph_o, out_quad_o}, 32'hAAAAAAAA)
                9: `CHK({out_inph_o, out_quad_o}, 32'hFFFFFFFF)
                default: `CHK({out_inph_o, out_quad_o}, 32'h13572468)
            endcase
        end
    endtask
    task automatic t_gain();
        logic [15:0] sv [4] = '{16'h1234, 16'h7000, 16'h9000, 16'h1234};
        logic [15:0] ev [4] = '{16'h2468, 16'h7FFF, 16'h8000, 16'h1234};
        logic [31:0] c0;
        wr(8'h37, 8'h00);
        wr(8'h1F, 8'h01);
        foreach (sv[i]) begin
            @(posedge mclk_i);
            smp_inph_i <= sv[i];
            smp_quad_i <= sv[i];
            wb_path_i <= (i < 3);
            tick();
            `CHK({out_inph_o, out_quad_o}, {ev[i], ev[i]})
        end
        wr(8'h1F, 8'h00);
        @(posedge mclk_i);
        wb_path_i <= 1'b1;
        tick();
        `CHK(out_inph_o, 16'h1234)
        c0 = cnt;
        @(posedge mclk_i);
        smp_valid_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        smp_valid_i <= 1'b0;
        repeat (3) tick();
        `CHK(cnt - c0, 32'd5)
    endtask
    task automatic t_streams();
        wr(8'h37, 8'h01);
        wr(8'h38, 8'h82);
        tick();
        tick();
        `CHK({out_inph_o, out_quad_o}, 32'h0)
        wr(8'h39, 8'h01);
        tick();
        tick();
        `CHK({out_inph_o, out_quad_o}, 32'hFFFFAAAA)
    endtask
    // timeout well above the few hundred cycles the run needs
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        {mclk_i, arst_n_i, reg_wr_i, smp_valid_i, wb_path_i} = 5'h0;
        {reg_addr_i, reg_wdata_i} = 16'h0;
        smp_inph_i = 16'h1357;
        smp_quad_i = 16'h2468;
        repeat (16) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_patterns();
        t_gain();
        t_streams();
        results();
    end
endmodule
`default_nettype wire
